/* core/tmc_pkg.sv */
`default_nettype none
package tmc_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CH = 6;
    localparam int ADDR_W = 6;
    localparam int REG_W = 8;

    // ------------------------------------------------------------
    // Register byte offsets (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE_BASE = 6'h00; // Mode regs ch0..ch5 at 0x00..0x14
    localparam logic [ADDR_W-1:0] OFS_IOC_BASE = 6'h18;  // High/single io regs ch0..ch5 at 0x18..0x2c
    localparam logic [ADDR_W-1:0] OFS_IOC_LOW_CH0 = 6'h30;
    localparam logic [ADDR_W-1:0] OFS_IOC_LOW_CH3 = 6'h34;
    localparam logic [ADDR_W-1:0] OFS_START = 6'h38;     // Counter start bits, one per channel

    // ------------------------------------------------------------
    // Mode register fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_BFB_BIT = 5;
    localparam int MODE_BFA_BIT = 4;
    localparam int MODE_MSB_BIT = 3;
    localparam int MODE_PHASE_BIT = 2;
    localparam logic [1:0] MODE_TOP_ONES = 2'h3;
    localparam logic [REG_W-1:0] MODE_RESET = 8'hc0;
    localparam logic [REG_W-1:0] IOC_RESET = 8'h00;

    // ------------------------------------------------------------
    // Decoded operating modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TMC_NORMAL = 4'h0,
        TMC_RESERVED = 4'h1,
        TMC_PWM1 = 4'h2,
        TMC_PWM2 = 4'h3,
        TMC_PHASE1 = 4'h4,
        TMC_PHASE2 = 4'h5,
        TMC_PHASE3 = 4'h6,
        TMC_PHASE4 = 4'h7,
        TMC_UNDEF = 4'h8
    } tmc_mode_e;

    // True for channels that own general registers C and D
    function automatic logic has_cd(input int ch);
        return (ch == 0) || (ch == 3);
    endfunction
endpackage : tmc_pkg
`default_nettype wire

/* core/tmc_cfg_if.sv */
`default_nettype none
// Channel configuration carried from the register file to the decoder
interface tmc_cfg_if;
    logic [7:0] mode [6];
    logic [7:0] ioc_hi [6];
    logic [7:0] ioc_lo [6];
    logic [5:0] start;
    modport src (output mode, output ioc_hi, output ioc_lo, output start);
    modport dst (input mode, input ioc_hi, input ioc_lo, input start);
endinterface : tmc_cfg_if
`default_nettype wire

/* core/tmc_chan_dec.sv */
`default_nettype none
// ------------------------------------------------------------
// Per-channel mode and pin function decoder
// ------------------------------------------------------------
module tmc_chan_dec (
    tmc_cfg_if.dst cfg,
    output logic [23:0] mode_o,
    output logic [5:0] pwm2_o,
    output logic [5:0] init_load_o,
    output logic [23:0] ioc_a_o,
    output logic [23:0] ioc_b_o,
    output logic [23:0] ioc_c_o,
    output logic [23:0] ioc_d_o,
    output logic [5:0] c_active_o,
    output logic [5:0] d_active_o
);
    // Map a raw mode field to the operating mode
    // Channels with C and D have no phase inputs, so a phase code there is undefined
    function automatic tmc_pkg::tmc_mode_e dec_mode(input int ch, input logic [3:0] f);
        if (f[tmc_pkg::MODE_MSB_BIT]) begin
            return tmc_pkg::TMC_UNDEF;
        end
        if (tmc_pkg::has_cd(ch) && f[tmc_pkg::MODE_PHASE_BIT]) begin
            return tmc_pkg::TMC_UNDEF;
        end
        return tmc_pkg::tmc_mode_e'(f);
    endfunction

    // Combinational decode of every channel
    always_comb begin
        for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
            mode_o[ch*4 +: 4] = dec_mode(ch, cfg.mode[ch][3:0]);
            pwm2_o[ch] = (dec_mode(ch, cfg.mode[ch][3:0]) == tmc_pkg::TMC_PWM2);
            // Initial level applies while the counter is stopped, decided by the start bit alone
            init_load_o[ch] = !cfg.start[ch];
            ioc_a_o[ch*4 +: 4] = cfg.ioc_hi[ch][3:0];
            ioc_b_o[ch*4 +: 4] = cfg.ioc_hi[ch][7:4];
            // A buffered C/D loses its own function entirely
            c_active_o[ch] = tmc_pkg::has_cd(ch) && !cfg.mode[ch][tmc_pkg::MODE_BFA_BIT];
            d_active_o[ch] = tmc_pkg::has_cd(ch) && !cfg.mode[ch][tmc_pkg::MODE_BFB_BIT];
            ioc_c_o[ch*4 +: 4] = c_active_o[ch] ? cfg.ioc_lo[ch][3:0] : 4'h0;
            ioc_d_o[ch*4 +: 4] = d_active_o[ch] ? cfg.ioc_lo[ch][7:4] : 4'h0;
        end
    end
endmodule : tmc_chan_dec
`default_nettype wire

/* core/tmc_top.sv */
// Functional notes
// - One mode register per each of six channels
// - Mode bits 7 and 6 read one, ignore writes
// - Bit 5 pairs B with D buffer
// - Bit 4 pairs A with C buffer
// - Buffer bits reserved zero on channels 1,2,4,5
// - Mode field decodes normal, PWM, phase counting
// - Channels 0 and 3 lack phase counting
// - Eight io control registers, low for 0,3
// - High register: B upper nibble, A lower
// - Initial output valid while counter stopped
// - PWM mode 2 initial level at clear (only flagged on pwm2_o; init_load_o follows the start bit alone)
// - Buffered C or D ignores io setting
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`default_nettype none
module tmc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [23:0] mode_o,
    output logic [5:0] pwm2_o,
    output logic [5:0] init_load_o,
    output logic [5:0] start_o,
    output logic [23:0] ioc_a_o,
    output logic [23:0] ioc_b_o,
    output logic [23:0] ioc_c_o,
    output logic [23:0] ioc_d_o,
    output logic [5:0] c_active_o,
    output logic [5:0] d_active_o
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] mode_ff [6];
    logic [7:0] ioc_hi_ff [6];
    logic [7:0] ioc_lo_ff [6];
    logic [5:0] start_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] rdat_ff;
    logic req;
    logic hit;
    logic wr_en;
    logic [7:0] nxt_rdat;

    tmc_cfg_if cfg ();

    // Request is new only when no ack is pending, so each cycle answers once
    assign req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign wr_en = req && hit && wb_we_i && wb_sel_i[0];

    // Write value for a mode register, keeping reserved bits fixed
    function automatic logic [7:0] mode_wval(input int ch, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        v[7:6] = tmc_pkg::MODE_TOP_ONES;
        if (!tmc_pkg::has_cd(ch)) begin
            v[tmc_pkg::MODE_BFB_BIT] = 1'b0;
            v[tmc_pkg::MODE_BFA_BIT] = 1'b0;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------
    always_comb begin
        hit = 1'b0;
        nxt_rdat = 8'h00;
        for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
            if (wb_adr_i == tmc_pkg::OFS_MODE_BASE + 6'(ch * 4)) begin
                hit = 1'b1;
                nxt_rdat = mode_ff[ch];
            end
            if (wb_adr_i == tmc_pkg::OFS_IOC_BASE + 6'(ch * 4)) begin
                hit = 1'b1;
                nxt_rdat = ioc_hi_ff[ch];
            end
        end
        if (wb_adr_i == tmc_pkg::OFS_IOC_LOW_CH0) begin
            hit = 1'b1;
            nxt_rdat = ioc_lo_ff[0];
        end
        if (wb_adr_i == tmc_pkg::OFS_IOC_LOW_CH3) begin
            hit = 1'b1;
            nxt_rdat = ioc_lo_ff[3];
        end
        if (wb_adr_i == tmc_pkg::OFS_START) begin
            hit = 1'b1;
            nxt_rdat = {2'h0, start_ff};
        end
    end

    // ------------------------------------------------------------
    // Bus answer: ack one cycle after the request, err if unmapped
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff <= req && hit;
            err_ff <= req && !hit;
            rdat_ff <= (req && hit && !wb_we_i) ? {24'h0, nxt_rdat} : 32'h0;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdat_ff;

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    // Not blocked while running: halting first is left to software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
                mode_ff[ch] <= tmc_pkg::MODE_RESET;
            end
        end else if (wr_en) begin
            for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
                if (wb_adr_i == tmc_pkg::OFS_MODE_BASE + 6'(ch * 4)) begin
                    mode_ff[ch] <= mode_wval(ch, wb_dat_i[7:0]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // I/O control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
                ioc_hi_ff[ch] <= tmc_pkg::IOC_RESET;
                ioc_lo_ff[ch] <= tmc_pkg::IOC_RESET;
            end
        end else if (wr_en) begin
            for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
                if (wb_adr_i == tmc_pkg::OFS_IOC_BASE + 6'(ch * 4)) begin
                    ioc_hi_ff[ch] <= wb_dat_i[7:0];
                end
            end
            if (wb_adr_i == tmc_pkg::OFS_IOC_LOW_CH0) begin
                ioc_lo_ff[0] <= wb_dat_i[7:0];
            end
            if (wb_adr_i == tmc_pkg::OFS_IOC_LOW_CH3) begin
                ioc_lo_ff[3] <= wb_dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter start bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_ff <= 6'h00;
        end else if (wr_en && wb_adr_i == tmc_pkg::OFS_START) begin
            start_ff <= wb_dat_i[5:0];
        end
    end

    // ------------------------------------------------------------
    // Configuration to decoder
    // ------------------------------------------------------------
    always_comb begin
        for (int ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin
            cfg.mode[ch] = mode_ff[ch];
            cfg.ioc_hi[ch] = ioc_hi_ff[ch];
            // Only channels with C and D have a low register
            cfg.ioc_lo[ch] = tmc_pkg::has_cd(ch) ? ioc_lo_ff[ch] : 8'h00;
        end
        cfg.start = start_ff;
    end
    assign start_o = start_ff;

    tmc_chan_dec u_dec (
        .cfg(cfg.dst),
        .mode_o(mode_o),
        .pwm2_o(pwm2_o),
        .init_load_o(init_load_o),
        .ioc_a_o(ioc_a_o),
        .ioc_b_o(ioc_b_o),
        .ioc_c_o(ioc_c_o),
        .ioc_d_o(ioc_d_o),
        .c_active_o(c_active_o),
        .d_active_o(d_active_o)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    mode_top_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_ff[1][7:6] == 2'h3 && mode_ff[0][7:6] == 2'h3) else $error("mode top bits not ones");
    buf_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_ff[2][5:4] == 2'h0 && mode_ff[5][5:4] == 2'h0) else $error("reserved buffer bit set");
    d_buffer_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_ff[0][5] |-> !d_active_o[0] && ioc_d_o[3:0] == 4'h0) else $error("buffered D still active");
    c_buffer_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_ff[3][4] |-> !c_active_o[3] && ioc_c_o[15:12] == 4'h0) else $error("buffered C still active");
    mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && wb_adr_i == 6'h04 |=> mode_ff[1] == {2'h3, 2'h0, $past(wb_dat_i[3:0])})
        else $error("mode write lost");
    pwm2_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_ff[2][3:0] == 4'h3 |-> pwm2_o[2] && mode_o[11:8] == 4'h3) else $error("pwm2 decode wrong");
    ioc_nibble_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ioc_b_o[23:20] == ioc_hi_ff[5][7:4] && ioc_a_o[3:0] == ioc_hi_ff[0][3:0]) else $error("io nibble wrong");
    init_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && wb_adr_i == tmc_pkg::OFS_START && wb_dat_i[0] |=> !init_load_o[0]) else $error("initial load while run");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    cov_pwm2: cover property (@(posedge clk_i) pwm2_o[0]);
    cov_buf: cover property (@(posedge clk_i) !d_active_o[3]);
    cov_err: cover property (@(posedge clk_i) wb_err_o);
    cov_phase: cover property (@(posedge clk_i) mode_o[7:4] == 4'(tmc_pkg::TMC_PHASE4));
    cov_run: cover property (@(posedge clk_i) start_o[3] && !init_load_o[3]);

    // ------------------------------------------------------------
    // Bus answer checks
    // ------------------------------------------------------------
    // Read data is zero outside the answer cycle, so a stale value never leaks
    rdat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside answer");
    // A cycle is answered by ack or by err, never both
    ack_err_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    // Unmapped address is refused one cycle after the request
    err_unmap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !hit |=> wb_err_o)
        else $error("unmapped access not refused");
    // A write without its byte lane leaves the start bits and the low register of channel 3 alone
    write_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && hit && wb_we_i && !wb_sel_i[0] |=> $stable(start_ff) && $stable(ioc_lo_ff[3]))
        else $error("write without lane landed");
    // Low register of channel 3 keeps what was written
    ioc_low_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && wb_adr_i == tmc_pkg::OFS_IOC_LOW_CH3 |=> ioc_lo_ff[3] == $past(wb_dat_i[7:0]))
        else $error("low io write lost");
    // Start bits reach the outputs unchanged
    start_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && wb_adr_i == tmc_pkg::OFS_START |=> start_o == $past(wb_dat_i[5:0]))
        else $error("start write lost");

    // ------------------------------------------------------------
    // Per-channel checks
    // ------------------------------------------------------------
    // One copy per channel, so no channel slips past a spot check
    for (genvar ch = 0; ch < tmc_pkg::NUM_CH; ch++) begin : g_chk
        localparam bit HAS_CD = tmc_pkg::has_cd(ch);
        // Reserved top bits hold their fixed ones
        mode_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
            mode_ff[ch][7:6] == tmc_pkg::MODE_TOP_ONES)
            else $error("mode top bits changed");
        // Channels without C and D never keep a buffer bit
        buf_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
            HAS_CD || (!mode_ff[ch][tmc_pkg::MODE_BFB_BIT] && !mode_ff[ch][tmc_pkg::MODE_BFA_BIT]))
            else $error("reserved buffer bit kept");
        // C loses its own function while it buffers A
        c_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
            c_active_o[ch] == (HAS_CD && !mode_ff[ch][tmc_pkg::MODE_BFA_BIT]))
            else $error("C function gate wrong");
        // D loses its own function while it buffers B
        d_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
            d_active_o[ch] == (HAS_CD && !mode_ff[ch][tmc_pkg::MODE_BFB_BIT]))
            else $error("D function gate wrong");
        // A buffering C or D shows no io setting of its own
        cd_setting_a: assert property (@(posedge clk_i) disable iff (rst_i)
            (c_active_o[ch] || ioc_c_o[ch*4 +: 4] == 4'h0) && (d_active_o[ch] || ioc_d_o[ch*4 +: 4] == 4'h0))
            else $error("buffer io setting leaks");
        // Channels with C and D never decode a phase counting mode
        phase_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
            !HAS_CD || mode_o[ch*4 +: 4] < 4'(tmc_pkg::TMC_PHASE1) || mode_o[ch*4 +: 4] == 4'(tmc_pkg::TMC_UNDEF))
            else $error("phase mode on channel without it");
        // A field with its MSB set decodes as undefined
        msb_undef_a: assert property (@(posedge clk_i) disable iff (rst_i)
            mode_ff[ch][tmc_pkg::MODE_MSB_BIT] |-> mode_o[ch*4 +: 4] == 4'(tmc_pkg::TMC_UNDEF))
            else $error("MSB set not undefined");
        // Initial level applies exactly while the counter is stopped
        init_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
            init_load_o[ch] == !start_ff[ch])
            else $error("initial load mismatch");
        // Both nibbles of the high or single register reach their outputs
        ioc_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
            ioc_a_o[ch*4 +: 4] == ioc_hi_ff[ch][3:0] && ioc_b_o[ch*4 +: 4] == ioc_hi_ff[ch][7:4])
            else $error("io nibble split wrong");
        // PWM mode 2 flag follows the mode field
        pwm2_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
            pwm2_o[ch] == (mode_ff[ch][3:0] == 4'(tmc_pkg::TMC_PWM2)))
            else $error("pwm2 flag wrong");
    end : g_chk
endmodule : tmc_top
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wb_err_o;
    logic [23:0] mode_o, ioc_a_o, ioc_b_o, ioc_c_o, ioc_d_o;
    logic [5:0] pwm2_o, init_load_o, start_o, c_active_o, d_active_o;
    logic [31:0] rdat;
    logic rerr;
    int n_fail = 0;
    int checks_done = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    tmc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .mode_o(mode_o), .pwm2_o(pwm2_o), .init_load_o(init_load_o), .start_o(start_o),
        .ioc_a_o(ioc_a_o), .ioc_b_o(ioc_b_o), .ioc_c_o(ioc_c_o), .ioc_d_o(ioc_d_o), .c_active_o(c_active_o),
        .d_active_o(d_active_o));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic single cycle; bounded wait so a dead slave ends the run
    task automatic bus(input logic we, input int adr, input logic [7:0] dat, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr[5:0];
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        rerr = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic wr(input int adr, input logic [7:0] dat);
        bus(1'b1, adr, dat, 4'h1);
    endtask

    task automatic rdc(input string nm, input int adr, input logic [31:0] exp);
        bus(1'b0, adr, 8'h00, 4'hf);
        chk(nm, exp, rdat);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values of every register but the start bits, and of mode_o and c_active_o
    task automatic t_reset();
        for (int ch = 0; ch < 6; ch++) begin
            rdc("mode_rst", 4 * ch, 32'h0000_00c0);
            rdc("ioc_rst", 8'h18 + 4 * ch, 32'h0);
        end
        rdc("ioc_low0_rst", 8'h30, 32'h0);
        rdc("ioc_low3_rst", 8'h34, 32'h0);
        chk("mode_o_rst", 32'h0, {8'h0, mode_o});
        chk("c_act_rst", 32'h09, {26'h0, c_active_o});
    endtask

    // Fixed top bits and reserved buffer bits; software keeps field MSB and phase bit clear
    task automatic t_mode();
        for (int ch = 0; ch < 6; ch++) begin
            wr(4 * ch, 8'hf3);
            rdc("mode_ff", 4 * ch, (ch % 3 == 0) ? 32'hf3 : 32'hc3);
            chk("mode_pwm2", 32'h3, {28'h0, mode_o[ch*4 +: 4]});
            chk("pwm2_all", 32'h1, {31'h0, pwm2_o[ch]});
            wr(4 * ch, 8'h00);
            rdc("mode_00", 4 * ch, 32'hc0);
        end
    endtask

    // Mode codes 0 to 7 on a phase-capable channel
    task automatic t_decode();
        for (int code = 0; code < 8; code++) begin
            wr(4, code[7:0]);
            chk("mode_dec", code, {28'h0, mode_o[7:4]});
            chk("pwm2", (code == 3) ? 32'h1 : 32'h0, {31'h0, pwm2_o[1]});
        end
        wr(4, 8'h00);
    endtask

    // Nibble split of high and single io registers, writes to both low registers, readback of channel 3 low only
    // Capture codes assume the pin is set up as an input outside this block
    task automatic t_ioc();
        logic [7:0] v;
        for (int ch = 0; ch < 6; ch++) begin
            v = 8'h5a ^ ch[7:0];
            wr(8'h18 + 4 * ch, v);
            rdc("ioc_rd", 8'h18 + 4 * ch, {24'h0, v});
            chk("ioc_a", {28'h0, v[3:0]}, {28'h0, ioc_a_o[ch*4 +: 4]});
            chk("ioc_b", {28'h0, v[7:4]}, {28'h0, ioc_b_o[ch*4 +: 4]});
        end
        wr(8'h30, 8'ha5);
        wr(8'h34, 8'h3c);
        rdc("ioc_low3", 8'h34, 32'h3c);
    endtask

    // All four buffer pairings on the channels that own C and D
    task automatic t_buffer();
        logic [7:0] lv;
        logic [1:0] b;
        for (int ch = 0; ch < 6; ch += 3) begin
            lv = (ch == 0) ? 8'ha5 : 8'h3c;
            for (int k = 0; k < 4; k++) begin
                b = k[1:0];
                wr(4 * ch, {2'b00, b, 4'h0});
                chk("c_act", {31'h0, ~b[0]}, {31'h0, c_active_o[ch]});
                chk("d_act", {31'h0, ~b[1]}, {31'h0, d_active_o[ch]});
                chk("ioc_c", b[0] ? 32'h0 : {28'h0, lv[3:0]}, {28'h0, ioc_c_o[ch*4 +: 4]});
                chk("ioc_d", b[1] ? 32'h0 : {28'h0, lv[7:4]}, {28'h0, ioc_d_o[ch*4 +: 4]});
            end
            wr(4 * ch, 8'h00);
        end
        chk("cd_none", 32'h0, {8'h0, ioc_c_o[23:16], ioc_c_o[11:4], ioc_d_o[23:16]});
    endtask

    // Initial level applies only to stopped channels
    task automatic t_start();
        wr(8'h38, 8'h2d);
        chk("start", 32'h2d, {26'h0, start_o});
        chk("init_load", 32'h12, {26'h0, init_load_o});
        wr(8'h38, 8'h00);
        chk("init_all", 32'h3f, {26'h0, init_load_o});
    endtask

    // Unmapped address and a write without its byte lane
    task automatic t_refuse();
        bus(1'b1, 8'h3c, 8'h55, 4'h1);
        chk("err_unmap", 32'h1, {31'h0, rerr});
        bus(1'b1, 8, 8'h03, 4'he);
        rdc("sel_off", 8, 32'hc0);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mode();
        t_decode();
        t_ioc();
        t_buffer();
        t_start();
        t_refuse();
        final_report();
    end
endmodule // tb
`default_nettype wire
